// ---- hdl/ror_fifo.sv ----
// FIFO, pop data valid the cycle after the pop
`timescale 1ns/1ps
`default_nettype none
module ror_fifo #(parameter int W = 16, parameter int D = 512) (
  input wire logic mclk_i,
  input wire logic rst_i,
  ror_fifo_if.fifo bus
);
  localparam int AW = $clog2(D);
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;
  logic [AW:0] level;
  logic do_push;
  logic do_pop;
  assign level = wp_reg - rp_reg;
  assign bus.full = (level == (AW+1)'(D));
  assign bus.afull = (level >= (AW+1)'(D - 2));
  assign bus.empty = (level == '0);
  assign do_push = bus.push & ~bus.full;
  assign do_pop = bus.pop & ~bus.empty;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_reg + (AW+1)'(do_push);
      rp_reg <= rp_reg + (AW+1)'(do_pop);
    end
  end
  ror_mem #(.W(W), .D(D)) u_mem (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .we_i(do_push),
    .waddr_i(wp_reg[AW-1:0]),
    .wdata_i(bus.wdata),
    .raddr_i(rp_reg[AW-1:0]),
    .rdata_o(bus.rdata)
  );
endmodule
`default_nettype wire

// ---- hdl/ror_fifo_if.sv ----
// FIFO push and pop carrier
`timescale 1ns/1ps
`default_nettype none
interface ror_fifo_if #(parameter int W = 16);
  logic push;
  logic pop;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic full;
  logic afull;
  logic empty;
  modport fifo(input push, pop, wdata, output rdata, full, afull, empty);
  modport user(output push, pop, wdata, input rdata, full, afull, empty);
endinterface
`default_nettype wire

// ---- hdl/ror_mem.sv ----
// Simple dual-port memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module ror_mem #(parameter int W = 16, parameter int D = 512) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [$clog2(D)-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [$clog2(D)-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] mem [0:D-1];
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule
`default_nettype wire

// ---- hdl/ror_pkg.sv ----
// Constants, types and timing for the reading output router
package ror_pkg;
  localparam int unsigned CLK_NS = 20;
  // ---------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ROUTE = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CNT_MIN = 8'h0c;
  localparam logic [7:0] OFS_CNT_MAX = 8'h10;
  localparam logic [7:0] OFS_SIZE = 8'h14;
  localparam logic [7:0] OFS_SIZE_MIN = 8'h18;
  localparam logic [7:0] OFS_SIZE_MAX = 8'h1c;
  localparam logic [7:0] OFS_BASE = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;
  // ---------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------
  localparam int CB_EXT = 0;
  localparam int CB_AZ = 1;
  localparam int CB_APER = 4;
  localparam int CB_CONF = 8;
  localparam int CB_READ = 9;
  localparam int CB_INIT = 10;
  localparam int SB_BUSY = 0;
  localparam int SB_ARMED = 1;
  localparam int SB_OOM = 2;
  localparam int SB_OVF = 3;
  localparam int SB_CFG = 4;
  localparam int SEL_POS = 24;
  localparam logic [1:0] SEL_MIN = 2'h1;
  localparam logic [1:0] SEL_MAX = 2'h2;
  // ---------------------------------------------------------
  // Limits and reset values
  // ---------------------------------------------------------
  localparam logic [23:0] COUNT_MIN = 24'h000001;
  localparam logic [23:0] COUNT_MAX = 24'hffffff;
  localparam logic [23:0] COUNT_RST = 24'h000001;
  localparam logic [23:0] SIZE_MIN = 24'h000000;
  localparam logic [23:0] SIZE_MAX = 24'hc00000;
  localparam logic [23:0] BASE_MIN = 24'h200000;
  localparam logic [23:0] BASE_MAX = 24'hdffffc;
  localparam logic [24:0] ADDR_LIMIT = 25'h0e00000;
  localparam logic [23:0] WORD_BYTES = 24'h000004;
  localparam logic [2:0] APER_10US = 3'h0;
  localparam logic [2:0] APER_MAX = 3'h6;
  localparam int RDG_W = 16;
  localparam int RDG_DEPTH = 512;
  localparam int OUT_W = 9;
  localparam int OUT_DEPTH = 128;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ALPHA = 8'h57;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_LF = 8'h0a;
  // ---------------------------------------------------------
  // Strobe low times, index is aperture * 2 + autozero
  // ---------------------------------------------------------
  typedef int unsigned ror_low_type [0:13];
  localparam ror_low_type LOW_NS = '{70000, 70000, 250000, 520000, 430000, 3100000,
    390000, 17200000, 370000, 20500000, 370000, 370000, 350000, 350000000};
  function automatic ror_low_type ror_cyc_fn(input ror_low_type ns);
    ror_low_type c;
    for (int i = 0; i < 14; i++) begin
      c[i] = (ns[i] / CLK_NS < 1) ? 1 : ns[i] / CLK_NS;
    end
    return c;
  endfunction
  localparam ror_low_type LOW_CYC_DFLT = ror_cyc_fn(LOW_NS);
  // ---------------------------------------------------------
  // State machines
  // ---------------------------------------------------------
  typedef enum logic [2:0] {A_IDLE = 3'b001, A_WAIT = 3'b010, A_RUN = 3'b100} ror_acq_type;
  typedef enum logic [4:0] {F_IDLE = 5'b00001, F_W1 = 5'b00010, F_W2 = 5'b00100,
    F_EMIT = 5'b01000, F_SEP = 5'b10000} ror_fmt_type;
endpackage

// ---- hdl/ror_router.sv ----
// Reading output router top level
`timescale 1ns/1ps
`default_nettype none
module ror_router #(parameter ror_pkg::ror_low_type LOW_CYC = ror_pkg::LOW_CYC_DFLT) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic trigger_i,
  input wire logic rdg_valid_i,
  input wire logic [31:0] rdg_data_i,
  output logic rdg_ready_o,
  input wire logic host_rd_i,
  output logic host_avail_o,
  output logic [7:0] host_byte_o,
  output logic host_eoi_o,
  output logic ext_wr_o,
  output logic [23:0] ext_addr_o,
  output logic [31:0] ext_data_o,
  output logic reading_done_output_n_o,
  output logic [7:0] backplane_trigger_line_o,
  output logic [7:0] backplane_trigger_line_oe_o,
  output logic busy_o
);
  import ror_pkg::*;

  // ---------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------
  logic ext_store_enable_reg;
  logic az_reg;
  logic [2:0] aper_reg;
  logic [23:0] readings_per_trigger_reg;
  logic [7:0] strobe_line_route_enable_reg;
  logic [23:0] ext_store_bytes_reg;
  logic [23:0] base_reg;
  logic oom_reg;
  logic ovf_reg;
  logic cfg_reg;
  ror_acq_type acq_reg;
  ror_fmt_type fmt_reg;
  logic [23:0] remain_reg;
  logic [23:0] fmt_left_reg;
  logic [23:0] offs_reg;
  logic dest_ext_reg;
  logic two_reg;
  logic pend_reg;
  logic [15:0] pend_data_reg;
  logic [31:0] word_reg;
  logic [2:0] dig_reg;
  logic [24:0] low_cnt_reg;
  logic strobe_n_reg;
  logic [1:0] wsel;
  logic [23:0] wval;
  logic wr_ctrl;
  logic wr_count;
  logic wr_size;
  logic wr_base;
  logic wr_stat;
  logic [23:0] count_next;
  logic [23:0] size_next;
  logic size_ok;
  logic base_ok;
  logic arm;
  logic accept;
  logic ext_fits;
  logic ovf_set;
  logic out_push_ok;
  logic [3:0] low_idx;

  ror_fifo_if #(.W(RDG_W)) rf();
  ror_fifo_if #(.W(OUT_W)) ob();

  // ---------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------
  assign wsel = reg_wdata_i[SEL_POS +: 2];
  assign wval = reg_wdata_i[23:0];
  assign wr_ctrl = reg_wr_i & (reg_addr_i == OFS_CTRL);
  assign wr_count = reg_wr_i & (reg_addr_i == OFS_COUNT);
  assign wr_size = reg_wr_i & (reg_addr_i == OFS_SIZE);
  assign wr_base = reg_wr_i & (reg_addr_i == OFS_BASE);
  assign wr_stat = reg_wr_i & (reg_addr_i == OFS_STAT);
  assign arm = wr_ctrl & (reg_wdata_i[CB_READ] | reg_wdata_i[CB_INIT]) & (acq_reg == A_IDLE);

  always_comb begin
    if (wsel == SEL_MIN) begin
      count_next = COUNT_MIN;
    end else if (wsel == SEL_MAX) begin
      count_next = COUNT_MAX;
    end else if (wval == 24'h000000) begin
      count_next = COUNT_MIN;
    end else begin
      count_next = wval;
    end
  end

  always_comb begin
    if (wsel == SEL_MIN) begin
      size_next = SIZE_MIN;
    end else if (wsel == SEL_MAX || wval > SIZE_MAX) begin
      size_next = SIZE_MAX;
    end else begin
      size_next = wval;
    end
  end

  assign size_ok = ({1'b0, base_reg} + {1'b0, size_next}) <= ADDR_LIMIT;
  assign base_ok = (wval >= BASE_MIN) && (wval <= BASE_MAX) && (wval[1:0] == 2'h0)
    && (({1'b0, wval} + {1'b0, ext_store_bytes_reg}) <= ADDR_LIMIT);

  // ---------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_store_enable_reg <= 1'b0;
      az_reg <= 1'b0;
      aper_reg <= APER_10US;
    end else if (wr_ctrl) begin
      ext_store_enable_reg <= reg_wdata_i[CB_EXT];
      az_reg <= reg_wdata_i[CB_AZ];
      if (reg_wdata_i[CB_APER +: 3] <= APER_MAX) begin
        aper_reg <= reg_wdata_i[CB_APER +: 3];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      readings_per_trigger_reg <= COUNT_RST;
    end else if (wr_ctrl && reg_wdata_i[CB_CONF]) begin
      readings_per_trigger_reg <= COUNT_RST;
    end else if (wr_count) begin
      readings_per_trigger_reg <= count_next;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_line_route_enable_reg <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == OFS_ROUTE) begin
      strobe_line_route_enable_reg <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_store_bytes_reg <= SIZE_MIN;
      base_reg <= BASE_MIN;
    end else begin
      if (wr_size && size_ok) begin
        ext_store_bytes_reg <= size_next;
      end
      if (wr_base && base_ok) begin
        base_reg <= wval;
      end
    end
  end

  // ---------------------------------------------------------
  // Error flags, set wins over clear
  // ---------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      oom_reg <= 1'b0;
      ovf_reg <= 1'b0;
      cfg_reg <= 1'b0;
    end else begin
      oom_reg <= (wr_count && count_next == COUNT_MAX) | (oom_reg & ~(wr_stat & reg_wdata_i[SB_OOM]));
      ovf_reg <= ovf_set | (ovf_reg & ~(wr_stat & reg_wdata_i[SB_OVF]));
      cfg_reg <= (wr_size & ~size_ok) | (wr_base & ~base_ok) | (cfg_reg & ~(wr_stat & reg_wdata_i[SB_CFG]));
    end
  end

  // ---------------------------------------------------------
  // Acquisition sequence
  // ---------------------------------------------------------
  assign accept = (acq_reg == A_RUN) & rdg_valid_i & rdg_ready_o;
  assign rdg_ready_o = (acq_reg == A_RUN) & ~rf.afull & ~pend_reg;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      acq_reg <= A_IDLE;
      remain_reg <= 24'h000000;
      dest_ext_reg <= 1'b0;
      two_reg <= 1'b0;
    end else begin
      case (acq_reg)
        A_IDLE: begin
          if (arm) begin
            acq_reg <= A_WAIT;
            dest_ext_reg <= reg_wdata_i[CB_INIT] & ~reg_wdata_i[CB_READ] & reg_wdata_i[CB_EXT];
            two_reg <= (reg_wdata_i[CB_APER +: 3] <= APER_MAX) ? (reg_wdata_i[CB_APER +: 3] != APER_10US)
              : (aper_reg != APER_10US);
          end
        end
        A_WAIT: begin
          if (trigger_i) begin
            acq_reg <= A_RUN;
            remain_reg <= readings_per_trigger_reg;
          end
        end
        A_RUN: begin
          if (accept) begin
            remain_reg <= remain_reg - 24'h000001;
            if (remain_reg == 24'h000001) begin
              acq_reg <= A_IDLE;
            end
          end
        end
        default: begin
          acq_reg <= A_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------
  // Reading FIFO fill, two words unless shortest aperture
  // ---------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_reg <= 1'b0;
      pend_data_reg <= 16'h0000;
    end else begin
      pend_reg <= accept & two_reg;
      if (accept) begin
        pend_data_reg <= rdg_data_i[15:0];
      end
    end
  end

  assign rf.push = accept | pend_reg;
  assign rf.wdata = pend_reg ? pend_data_reg : (two_reg ? rdg_data_i[31:16] : rdg_data_i[15:0]);

  ror_fifo #(.W(RDG_W), .D(RDG_DEPTH)) u_rdg_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .bus(rf.fifo)
  );

  // ---------------------------------------------------------
  // Reading complete strobe
  // ---------------------------------------------------------
  assign low_idx = {aper_reg, az_reg};

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt_reg <= 25'h0000000;
      strobe_n_reg <= 1'b1;
    end else if (accept) begin
      low_cnt_reg <= 25'(LOW_CYC[low_idx]) - 25'h0000001;
      strobe_n_reg <= 1'b0;
    end else if (low_cnt_reg != 25'h0000000) begin
      low_cnt_reg <= low_cnt_reg - 25'h0000001;
    end else begin
      strobe_n_reg <= 1'b1;
    end
  end

  assign reading_done_output_n_o = strobe_n_reg;
  assign backplane_trigger_line_o = 8'h00;
  assign backplane_trigger_line_oe_o = strobe_line_route_enable_reg & {8{~strobe_n_reg}};

  // ---------------------------------------------------------
  // Formatter and external memory writer
  // ---------------------------------------------------------
  function automatic logic [7:0] hex_fn(input logic [3:0] n);
    hex_fn = (n < 4'ha) ? CH_ZERO + {4'h0, n} : CH_ALPHA + {4'h0, n};
  endfunction

  assign ext_fits = ({1'b0, offs_reg} + {1'b0, WORD_BYTES}) <= {1'b0, ext_store_bytes_reg};
  assign ovf_set = (fmt_reg == F_EMIT) & dest_ext_reg & ~ext_fits;
  assign out_push_ok = ~ob.full;
  assign rf.pop = (fmt_reg == F_IDLE) | ((fmt_reg == F_W1) & two_reg);

  always_comb begin
    ob.push = 1'b0;
    ob.wdata = {1'b0, CH_COMMA};
    if (fmt_reg == F_EMIT && !dest_ext_reg) begin
      ob.push = out_push_ok;
      ob.wdata = {1'b0, hex_fn(word_reg[31:28])};
    end else if (fmt_reg == F_SEP) begin
      ob.push = out_push_ok;
      if (fmt_left_reg == 24'h000001) begin
        ob.wdata = {1'b1, CH_LF};
      end else begin
        ob.wdata = {1'b0, CH_COMMA};
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fmt_reg <= F_IDLE;
      word_reg <= 32'h00000000;
      dig_reg <= 3'h0;
      fmt_left_reg <= 24'h000000;
    end else begin
      if (acq_reg == A_WAIT && trigger_i) begin
        fmt_left_reg <= readings_per_trigger_reg;
      end
      case (fmt_reg)
        F_IDLE: begin
          if (!rf.empty) begin
            fmt_reg <= F_W1;
          end
        end
        F_W1: begin
          word_reg <= {rf.rdata, 16'h0000};
          dig_reg <= two_reg ? 3'h7 : 3'h3;
          fmt_reg <= two_reg ? F_W2 : F_EMIT;
        end
        F_W2: begin
          word_reg[15:0] <= rf.rdata;
          fmt_reg <= F_EMIT;
        end
        F_EMIT: begin
          if (dest_ext_reg) begin
            fmt_left_reg <= fmt_left_reg - 24'h000001;
            fmt_reg <= F_IDLE;
          end else if (out_push_ok) begin
            word_reg <= {word_reg[27:0], 4'h0};
            dig_reg <= dig_reg - 3'h1;
            if (dig_reg == 3'h0) begin
              fmt_reg <= F_SEP;
            end
          end
        end
        F_SEP: begin
          if (out_push_ok) begin
            fmt_left_reg <= fmt_left_reg - 24'h000001;
            fmt_reg <= F_IDLE;
          end
        end
        default: begin
          fmt_reg <= F_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      offs_reg <= 24'h000000;
      ext_wr_o <= 1'b0;
      ext_addr_o <= 24'h000000;
      ext_data_o <= 32'h00000000;
    end else begin
      ext_wr_o <= 1'b0;
      if (arm) begin
        offs_reg <= 24'h000000;
      end else if (fmt_reg == F_EMIT && dest_ext_reg && ext_fits) begin
        ext_wr_o <= 1'b1;
        ext_addr_o <= base_reg + offs_reg;
        ext_data_o <= two_reg ? word_reg : {16'h0000, word_reg[31:16]};
        offs_reg <= offs_reg + WORD_BYTES;
      end
    end
  end

  // ---------------------------------------------------------
  // Output buffer towards the host
  // ---------------------------------------------------------
  assign ob.pop = host_rd_i;

  ror_fifo #(.W(OUT_W), .D(OUT_DEPTH)) u_out_buf (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .bus(ob.fifo)
  );

  assign host_avail_o = ~ob.empty;
  assign host_byte_o = ob.rdata[7:0];
  assign host_eoi_o = ob.rdata[8];
  assign busy_o = ob.full | (acq_reg != A_IDLE);

  // ---------------------------------------------------------
  // Register read, data one cycle after the strobe
  // ---------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_CTRL: reg_rdata_o <= {25'h0000000, aper_reg, 2'h0, az_reg, ext_store_enable_reg};
        OFS_ROUTE: reg_rdata_o <= {24'h000000, strobe_line_route_enable_reg};
        OFS_COUNT: reg_rdata_o <= {8'h00, readings_per_trigger_reg};
        OFS_CNT_MIN: reg_rdata_o <= {8'h00, COUNT_MIN};
        OFS_CNT_MAX: reg_rdata_o <= {8'h00, COUNT_MAX};
        OFS_SIZE: reg_rdata_o <= {8'h00, ext_store_bytes_reg};
        OFS_SIZE_MIN: reg_rdata_o <= {8'h00, SIZE_MIN};
        OFS_SIZE_MAX: reg_rdata_o <= {8'h00, SIZE_MAX};
        OFS_BASE: reg_rdata_o <= {8'h00, base_reg};
        OFS_STAT: reg_rdata_o <= {27'h0000000, cfg_reg, ovf_reg, oom_reg, acq_reg == A_WAIT, busy_o};
        default: reg_rdata_o <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/ror_host_model.sv ----
// Host controller model that drains the output buffer
`timescale 1ns/1ps
`default_nettype none
module ror_host_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic host_avail_i,
  output logic host_rd_o,
  output logic got_o
);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      host_rd_o <= 1'b0;
      got_o <= 1'b0;
    end else begin
      host_rd_o <= host_avail_i & ~stall_i & ~host_rd_o;
      got_o <= host_rd_o & host_avail_i;
    end
  end
endmodule
`default_nettype wire

// ---- tb/ror_router_checker.sv ----
// Port assertions for the reading output router
`timescale 1ns/1ps
`default_nettype none
module ror_router_checker #(parameter ror_pkg::ror_low_type LOW_CYC = ror_pkg::LOW_CYC_DFLT) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic rdg_valid_i,
  input wire logic rdg_ready_o,
  input wire logic host_rd_i,
  input wire logic host_avail_o,
  input wire logic [7:0] host_byte_o,
  input wire logic host_eoi_o,
  input wire logic ext_wr_o,
  input wire logic reading_done_output_n_o,
  input wire logic [7:0] backplane_trigger_line_o,
  input wire logic [7:0] backplane_trigger_line_oe_o
);
  import ror_pkg::*;
  logic [6:0] ctl_reg;
  logic [7:0] route_reg;
  int unsigned low_reg;
  logic take;
  assign take = rdg_valid_i & rdg_ready_o;
  // Shadow of control and route settings
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_reg <= '0;
      route_reg <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == OFS_CTRL) ctl_reg <= reg_wdata_i[6:0];
      if (reg_addr_i == OFS_ROUTE) route_reg <= reg_wdata_i[7:0];
    end
  end
  // Low cycles since the last reading
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) low_reg <= 0;
    else if (take) low_reg <= 0;
    else if (!reading_done_output_n_o) low_reg <= low_reg + 1;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_line_low; backplane_trigger_line_o == 8'h00; endproperty
  a_line_low: assert property (p_line_low) else $error("line data not low");
  property p_oe_route; backplane_trigger_line_oe_o == (reading_done_output_n_o ? 8'h00 : route_reg); endproperty
  a_oe_route: assert property (p_oe_route) else $error("line enable wrong");
  property p_take_low; take |=> !reading_done_output_n_o; endproperty
  a_take_low: assert property (p_take_low) else $error("no strobe");
  property p_low_time; $rose(reading_done_output_n_o) |-> low_reg == LOW_CYC[{ctl_reg[6:4], ctl_reg[1]}]; endproperty
  a_low_time: assert property (p_low_time) else $error("strobe length wrong");
  property p_word_gap; take && ctl_reg[6:4] != APER_10US |=> !rdg_ready_o; endproperty
  a_word_gap: assert property (p_word_gap) else $error("second word not held");
  property p_cnt_max; reg_rd_i && reg_addr_i == OFS_CNT_MAX |=> reg_rdata_o == 32'h00ffffff; endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("count max wrong");
  property p_size_max; reg_rd_i && reg_addr_i == OFS_SIZE_MAX |=> reg_rdata_o == 32'h00c00000; endproperty
  a_size_max: assert property (p_size_max) else $error("size max wrong");
  property p_eoi_lf; host_rd_i && host_avail_o ##1 host_eoi_o |-> host_byte_o == CH_LF; endproperty
  a_eoi_lf: assert property (p_eoi_lf) else $error("end flag off line feed");
  property p_ext_on; ext_wr_o |-> ctl_reg[0]; endproperty
  a_ext_on: assert property (p_ext_on) else $error("store while disabled");
endmodule
`default_nettype wire

// ---- tb/test_reading_output_router.sv ----
// Self-checking bench for the reading output router
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin error_cnt++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module test_reading_output_router;
  import ror_pkg::*;
  localparam ror_low_type LOW_CYC = '{4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17};
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic trigger_i = 1'b0;
  logic rdg_valid_i = 1'b0;
  logic [31:0] rdg_data_i = 32'h0;
  logic stall = 1'b0;
  logic rd_q = 1'b0;
  logic host_rd_i, got, rdg_ready_o, host_avail_o, host_eoi_o, ext_wr_o, reading_done_output_n_o, busy_o;
  logic [7:0] host_byte_o, backplane_trigger_line_o, backplane_trigger_line_oe_o;
  logic [23:0] ext_addr_o;
  logic [31:0] reg_rdata_o, ext_data_o;
  logic [31:0] seed = 32'd2041;
  logic [55:0] x;
  logic [31:0] rq[$];
  logic [8:0] hq[$];
  logic [55:0] eq[$];
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  ror_router #(.LOW_CYC(LOW_CYC)) i_dut (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .trigger_i, .rdg_valid_i, .rdg_data_i, .rdg_ready_o, .host_rd_i, .host_avail_o, .host_byte_o,
    .host_eoi_o, .ext_wr_o, .ext_addr_o, .ext_data_o, .reading_done_output_n_o, .backplane_trigger_line_o,
    .backplane_trigger_line_oe_o, .busy_o);
  ror_host_model i_host (.mclk_i, .rst_i, .stall_i(stall), .host_avail_i(host_avail_o), .host_rd_o(host_rd_i),
    .got_o(got));
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'ha) ? CH_ZERO + v : CH_ALPHA + v;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
  endtask
  // Arm, trigger, offer n readings and note what must come out
  task automatic run(input logic [31:0] c, input int n, input int dg);
    logic [31:0] d;
    wr(OFS_CTRL, c);
    @(posedge mclk_i);
    trigger_i <= 1'b1;
    @(posedge mclk_i);
    trigger_i <= 1'b0;
    `CHK("busy", 1'b1, busy_o)
    for (int k = 0; k < n; k++) begin
      d = xs();
      @(posedge mclk_i);
      rdg_valid_i <= 1'b1;
      rdg_data_i <= d;
      @(posedge mclk_i);
      for (int t = 0; t < 300 && rdg_ready_o !== 1'b1; t++) @(posedge mclk_i);
      rdg_valid_i <= 1'b0;
      if (c[CB_INIT]) begin
        if (k < 2) eq.push_back({BASE_MIN + 24'(k * 4), d});
      end else begin
        for (int i = dg - 1; i >= 0; i--) hq.push_back({1'b0, hx(d[i*4 +: 4])});
        hq.push_back(k == n - 1 ? {1'b1, CH_LF} : {1'b0, CH_COMMA});
      end
    end
    for (int t = 0; t < 3000 && hq.size() + eq.size() > 0; t++) @(posedge mclk_i);
    repeat (20) @(posedge mclk_i);
    `CHK("left", 0, hq.size() + eq.size())
    $display("run %0h done", c);
  endtask
  always @(posedge mclk_i) begin
    stall <= xs() > 32'h9fffffff;
    rd_q <= reg_rd_i;
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      final_report();
    end
    if (rd_q) begin
      x = rq.pop_front();
      `CHK("reg", x[31:0], reg_rdata_o)
    end
    if (got) begin
      x = hq.pop_front();
      `CHK("host", x[8:0], {host_eoi_o, host_byte_o})
    end
    if (ext_wr_o) begin
      x = eq.pop_front();
      `CHK("ext", x, {ext_addr_o, ext_data_o})
    end
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(OFS_COUNT, 32'h1);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_ROUTE, 32'h0);
    rd(OFS_SIZE, 32'h0);
    rd(OFS_CNT_MAX, 32'hffffff);
    rd(OFS_SIZE_MAX, 32'hc00000);
    rd(8'h40, 32'h0);
    wr(OFS_COUNT, 32'h02000000);
    rd(OFS_COUNT, 32'hffffff);
    wr(OFS_COUNT, 32'h01000000);
    rd(OFS_COUNT, 32'h1);
    wr(OFS_COUNT, 32'h5);
    wr(OFS_CTRL, 32'h100);
    rd(OFS_COUNT, 32'h1);
    wr(OFS_SIZE, 32'h02000000);
    rd(OFS_SIZE, 32'hc00000);
    wr(OFS_BASE, 32'h300000);
    rd(OFS_BASE, 32'h200000);
    rd(OFS_STAT, 32'h14);
    wr(OFS_STAT, 32'h1c);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_CTRL, 32'h1);
    $display("register test done");
    wr(OFS_ROUTE, 32'ha5);
    wr(OFS_COUNT, 32'h3);
    run(32'h200, 3, 4);
    run(32'h212, 3, 8);
    wr(OFS_SIZE, 32'h8);
    run(32'h411, 3, 0);
    rd(OFS_STAT, 32'h8);
    rd(OFS_CTRL, 32'h11);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(OFS_ROUTE, 32'h0);
    rd(OFS_COUNT, 32'h1);
    $display("reset test done");
    repeat (3) @(posedge mclk_i);
    final_report();
  end
endmodule
bind ror_router ror_router_checker #(.LOW_CYC(LOW_CYC)) i_chk (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rdg_valid_i, .rdg_ready_o, .host_rd_i, .host_avail_o, .host_byte_o,
  .host_eoi_o, .ext_wr_o, .reading_done_output_n_o, .backplane_trigger_line_o, .backplane_trigger_line_oe_o);
`default_nettype wire
